// file: shared/adiv_params.svh
// Purpose: constants for the antenna diversity controller
// Assumes: 40 MHz clock, word-aligned classic Wishbone register map
// Notes:   offsets are byte addresses
`ifndef ADIV_PARAMS_SVH
`define ADIV_PARAMS_SVH

// ************************************************************
// timing
// ************************************************************
`define ADIV_CLK_PERIOD_PS  25000
`define ADIV_WINDOW_US      40
`define ADIV_WINDOW_CYC     ((`ADIV_WINDOW_US * 1000000) / `ADIV_CLK_PERIOD_PS)

// ************************************************************
// register offsets
// ************************************************************
`define ADIV_OFS_CTRL       8'h00
`define ADIV_OFS_THRESH     8'h04
`define ADIV_OFS_STATUS     8'h08
`define ADIV_OFS_SWAP       8'h0c

// ************************************************************
// field positions
// ************************************************************
`define ADIV_CTRL_TX_EN     0
`define ADIV_CTRL_RX_EN     1
`define ADIV_CTRL_OUT_EN    2
`define ADIV_CTRL_PIN_ALT   3
`define ADIV_THR_ENERGY_LSB 0
`define ADIV_THR_QUAL_LSB   8
`define ADIV_STAT_LAST_TX   0
`define ADIV_STAT_LAST_RX   1
`define ADIV_STAT_CURRENT   2
`define ADIV_SWAP_GO        0

// ************************************************************
// reset values
// ************************************************************
`define ADIV_CTRL_RST       4'h0
`define ADIV_THR_RST        8'h00

`endif

// file: shared/adiv_pkg.sv
// Purpose: types for the antenna diversity controller
// Assumes: nothing beyond the params header
// Notes:   antenna a is the reset choice
package adiv_pkg;

    // ************************************************************
    // antenna choice
    // ************************************************************
    typedef enum logic {
        ADIV_ANT_A = 1'b0,
        ADIV_ANT_B = 1'b1
    } adiv_ant_t;

endpackage

// file: design/adiv_tick.sv
// Purpose: periodic one-cycle enable for the energy sampling window
// Assumes: single clock
// Notes:   first pulse comes PERIOD cycles after reset release
`timescale 1ns/1ps
module adiv_tick #(
    parameter int PERIOD = 1600
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    logic [15:0] cnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt == 16'(PERIOD - 1)) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tick_spacing: assert property (tick |=> !tick) else $error("tick not single cycle");
endmodule // adiv_tick

// file: design/adiv_ctrl.sv
// Purpose: antenna diversity controller driving a two-position rf switch
// Assumes: radio and mac status inputs synchronous to clk
// Notes:   switch pins follow the antenna state one cycle later
//
// Operation
// - pattern 10 on the pair selects antenna a, 01 selects antenna b.
// - a pin-location bit routes the pair to default or alternative pins.
// - switch pins drive only once the output enable bit is set.
// - transmit and receive diversity have separate enables, usable together.
// - after a missing acknowledgement the retry goes out on the other antenna.
// - with transmit diversity on, toggle the antenna before every retry.
// - with receive diversity on, sample energy every 40 us against a threshold.
// - receive swap only when energy is below threshold and no packet arrives.
// - receive swap blocked by a good preamble in last 40 us or ack wait.
// - software writes both the energy and the preamble quality thresholds.
// - status shows last transmit, last receive and current antenna.
// - a software swap command toggles the current antenna at once.
`timescale 1ns/1ps
`include "adiv_params.svh"
module adiv_ctrl #(
    parameter int EW         = 8,
    parameter int WINDOW_CYC = `ADIV_WINDOW_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          retry_start,
    input  wire logic          tx_done,
    input  wire logic          rx_done,
    input  wire logic          rx_busy,
    input  wire logic          ack_wait,
    input  wire logic [EW-1:0] energy_level,
    input  wire logic          preamble_det,
    input  wire logic [EW-1:0] preamble_qual,
    output logic               sw_dflt_a,
    output logic               sw_dflt_b,
    output logic               sw_dflt_oe,
    output logic               sw_alt_a,
    output logic               sw_alt_b,
    output logic               sw_alt_oe
);

    // ************************************************************
    // state
    // ************************************************************
    logic                tx_div_en;
    logic                rx_div_en;
    logic                out_en;
    logic                pin_alt;
    logic [EW-1:0]       energy_thr;
    logic [EW-1:0]       qual_thr;
    adiv_pkg::adiv_ant_t ant;
    adiv_pkg::adiv_ant_t last_tx_ant;
    adiv_pkg::adiv_ant_t last_rx_ant;
    logic [15:0]         hold_cnt;
    logic                tick;

    logic                bus_req;
    logic                bus_wr;
    logic                hit_ctrl;
    logic                hit_thr;
    logic                hit_stat;
    logic                hit_swap;
    logic                man_swap;
    logic                tx_swap;
    logic                rx_swap;
    logic                pre_hit;
    logic [31:0]         next_rdata;

    // ************************************************************
    // 40 us sampling window
    // ************************************************************
    adiv_tick #(
        .PERIOD (WINDOW_CYC)
    ) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // ************************************************************
    // wishbone slave
    // ************************************************************
    assign bus_req  = wb_cyc_i && wb_stb_i;
    assign bus_wr   = bus_req && wb_we_i && wb_ack_o;
    assign hit_ctrl = wb_adr_i == `ADIV_OFS_CTRL;
    assign hit_thr  = wb_adr_i == `ADIV_OFS_THRESH;
    assign hit_stat = wb_adr_i == `ADIV_OFS_STATUS;
    assign hit_swap = wb_adr_i == `ADIV_OFS_SWAP;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_rdata[`ADIV_CTRL_TX_EN]   = tx_div_en;
            next_rdata[`ADIV_CTRL_RX_EN]   = rx_div_en;
            next_rdata[`ADIV_CTRL_OUT_EN]  = out_en;
            next_rdata[`ADIV_CTRL_PIN_ALT] = pin_alt;
        end else if (hit_thr) begin
            next_rdata[`ADIV_THR_ENERGY_LSB +: EW] = energy_thr;
            next_rdata[`ADIV_THR_QUAL_LSB +: EW]   = qual_thr;
        end else if (hit_stat) begin
            next_rdata[`ADIV_STAT_LAST_TX] = last_tx_ant;
            next_rdata[`ADIV_STAT_LAST_RX] = last_rx_ant;
            next_rdata[`ADIV_STAT_CURRENT] = ant;
        end
    end

    // ack one cycle after the request, dropped in the following cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= (bus_req && !wb_ack_o && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // ************************************************************
    // control and threshold registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_div_en <= 1'b0;
            rx_div_en <= 1'b0;
            out_en    <= 1'b0;
            pin_alt   <= 1'b0;
        end else if (bus_wr && hit_ctrl && wb_sel_i[0]) begin
            tx_div_en <= wb_dat_i[`ADIV_CTRL_TX_EN];
            rx_div_en <= wb_dat_i[`ADIV_CTRL_RX_EN];
            out_en    <= wb_dat_i[`ADIV_CTRL_OUT_EN];
            pin_alt   <= wb_dat_i[`ADIV_CTRL_PIN_ALT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            energy_thr <= EW'(`ADIV_THR_RST);
            qual_thr   <= EW'(`ADIV_THR_RST);
        end else if (bus_wr && hit_thr) begin
            if (wb_sel_i[0])
                energy_thr <= wb_dat_i[`ADIV_THR_ENERGY_LSB +: EW];
            if (wb_sel_i[1])
                qual_thr <= wb_dat_i[`ADIV_THR_QUAL_LSB +: EW];
        end
    end

    // ************************************************************
    // swap decisions
    // ************************************************************
    assign man_swap = bus_wr && hit_swap && wb_sel_i[0] && wb_dat_i[`ADIV_SWAP_GO];
    assign tx_swap  = tx_div_en && retry_start;
    assign pre_hit  = preamble_det && (preamble_qual > qual_thr);
    assign rx_swap  = rx_div_en && tick && (energy_level < energy_thr)
                   && !rx_busy && !ack_wait && (hold_cnt == 16'h0000);

    // good preamble blocks receive swaps for one full window
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            hold_cnt <= 16'h0000;
        else if (pre_hit)
            hold_cnt <= 16'(WINDOW_CYC);
        else if (hold_cnt != 16'h0000)
            hold_cnt <= hold_cnt - 16'h0001;
    end

    // simultaneous swap sources merge into a single toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ant <= adiv_pkg::ADIV_ANT_A;
        else if (man_swap || tx_swap || rx_swap)
            ant <= adiv_pkg::adiv_ant_t'(~ant);
    end

    // ************************************************************
    // antenna status
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_tx_ant <= adiv_pkg::ADIV_ANT_A;
            last_rx_ant <= adiv_pkg::ADIV_ANT_A;
        end else begin
            if (tx_done)
                last_tx_ant <= ant;
            if (rx_done)
                last_rx_ant <= ant;
        end
    end

    // ************************************************************
    // switch pins
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_dflt_a  <= 1'b0;
            sw_dflt_b  <= 1'b0;
            sw_dflt_oe <= 1'b0;
            sw_alt_a   <= 1'b0;
            sw_alt_b   <= 1'b0;
            sw_alt_oe  <= 1'b0;
        end else begin
            sw_dflt_oe <= out_en && !pin_alt;
            sw_alt_oe  <= out_en && pin_alt;
            sw_dflt_a  <= out_en && !pin_alt && (ant == adiv_pkg::ADIV_ANT_A);
            sw_dflt_b  <= out_en && !pin_alt && (ant == adiv_pkg::ADIV_ANT_B);
            sw_alt_a   <= out_en && pin_alt && (ant == adiv_pkg::ADIV_ANT_A);
            sw_alt_b   <= out_en && pin_alt && (ant == adiv_pkg::ADIV_ANT_B);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_good_preamble;
        preamble_det && (preamble_qual > qual_thr);
    endsequence

    sequence s_swap_write;
        bus_wr && hit_swap && wb_sel_i[0] && wb_dat_i[`ADIV_SWAP_GO];
    endsequence

    a_pin_pattern: assert property (
        sw_dflt_oe |-> (sw_dflt_a != sw_dflt_b) && (sw_dflt_b == $past(ant)))
        else $error("default pair pattern wrong");

    a_pin_alt_route: assert property (
        $past(out_en && pin_alt) |-> sw_alt_oe && !sw_dflt_oe && !sw_dflt_a && !sw_dflt_b
                                     && (sw_alt_a != sw_alt_b))
        else $error("alternative pair not routed");

    a_pin_gated_oe: assert property (
        !$past(out_en) |-> !sw_dflt_oe && !sw_alt_oe && !(sw_dflt_a || sw_dflt_b
                           || sw_alt_a || sw_alt_b))
        else $error("pins driven without output enable");

    a_no_auto_swap: assert property (
        (!tx_div_en && !rx_div_en && !man_swap) |=> ant == $past(ant))
        else $error("swap with diversity off");

    a_tx_retry_swap: assert property (
        (tx_div_en && retry_start) |=> ant != $past(ant))
        else $error("retry without antenna toggle");

    a_rx_swap_tick: assert property (
        (!tick && !tx_swap && !man_swap) |=> ant == $past(ant))
        else $error("receive swap off the sample tick");

    a_rx_energy_gate: assert property (
        ((energy_level >= energy_thr) || rx_busy) && !tx_swap && !man_swap
            |=> ant == $past(ant))
        else $error("receive swap with high energy or busy");

    a_rx_preamble_blk: assert property (
        s_good_preamble ##1 1'b1 |-> !rx_swap [*8])
        else $error("swap soon after good preamble");

    a_rx_ack_block: assert property (
        (ack_wait && !tx_swap && !man_swap) |=> ant == $past(ant))
        else $error("receive swap while ack awaited");

    a_thr_write: assert property (
        (bus_wr && hit_thr && wb_sel_i[1]) |=> qual_thr == $past(wb_dat_i[15:8]))
        else $error("quality threshold not written");

    a_last_rx_rec: assert property (
        rx_done |=> last_rx_ant == $past(ant))
        else $error("last receive antenna not recorded");

    a_manual_swap: assert property (
        s_swap_write |=> (ant != $past(ant)) ##1 (sw_dflt_b == ant || !sw_dflt_oe))
        else $error("manual swap not applied");

endmodule // adiv_ctrl

// file: test/adiv_switch_model.sv
// Purpose: two-position rf switch fed by both complementary pin pairs
// Assumes: only one pair drives at a time
// Notes:   linked is low when no pair drives or a pair shows 00 or 11
`timescale 1ns/1ps
module adiv_switch_model (
    input  wire logic dflt_a,
    input  wire logic dflt_b,
    input  wire logic dflt_oe,
    input  wire logic alt_a,
    input  wire logic alt_b,
    input  wire logic alt_oe,
    output logic      linked,
    output logic      ant_b
);
    // ************************************************************
    // switch position
    // ************************************************************
    always_comb begin
        linked = 1'b0;
        ant_b  = 1'b0;
        if (dflt_oe && !alt_oe) begin
            linked = dflt_a ^ dflt_b;
            ant_b  = dflt_b;
        end else if (alt_oe && !dflt_oe) begin
            linked = alt_a ^ alt_b;
            ant_b  = alt_b;
        end
    end
endmodule // adiv_switch_model

// file: test/testbench.sv
// Purpose: self-checking bench for the antenna diversity controller
// Assumes: wishbone access with one wait state, short energy window
// Notes:   window shortened to 16 cycles
`timescale 1ns/1ps
`include "adiv_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        clk, rst, cyc, stb, we, ack, retry, txd, rxd, busy, await_ack, pdet;
    logic [7:0]  adr, energy, qual;
    logic [31:0] wdat, rdat, q;
    logic [5:0]  pins;
    logic        linked, ant_b;
    int          err_count, num_checks, cycles, t;

    adiv_ctrl #(.WINDOW_CYC(16)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .retry_start(retry), .tx_done(txd), .rx_done(rxd), .rx_busy(busy),
        .ack_wait(await_ack), .energy_level(energy), .preamble_det(pdet),
        .preamble_qual(qual), .sw_dflt_a(pins[5]), .sw_dflt_b(pins[4]),
        .sw_dflt_oe(pins[3]), .sw_alt_a(pins[2]), .sw_alt_b(pins[1]), .sw_alt_oe(pins[0]));
    adiv_switch_model sw (.dflt_a(pins[5]), .dflt_b(pins[4]), .dflt_oe(pins[3]),
        .alt_a(pins[2]), .alt_b(pins[1]), .alt_oe(pins[0]), .linked(linked), .ant_b(ant_b));

    // ************************************************************
    // clock, timeout and verdict
    // ************************************************************
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        // ack and read data are taken at the rising edge that samples ack high
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (3) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // expected pins for output enable, alternative pair, antenna b
    function automatic logic [5:0] pv(input logic oe, input logic alt, input logic b);
        if (!oe) return 6'h00;
        return alt ? {3'b000, !b, b, 1'b1} : {!b, b, 1'b1, 3'b000};
    endfunction
    task automatic pin_chk(input logic [5:0] e);
        `CHK(pins, e)
        `CHK(linked, |e)
        `CHK(ant_b, e[4] | e[1])
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: retry <= 1'b1;
            1: txd <= 1'b1;
            2: rxd <= 1'b1;
            default: pdet <= 1'b1;
        endcase
        @(posedge clk);
        retry <= 1'b0;
        txd   <= 1'b0;
        rxd   <= 1'b0;
        pdet  <= 1'b0;
    endtask
    // waits, then counts sw_dflt_a changes over n cycles
    task automatic count(input int n);
        logic prev;
        repeat (4) @(negedge clk);
        prev = pins[5];
        t = 0;
        repeat (n) begin
            @(negedge clk);
            if (pins[5] !== prev) t++;
            prev = pins[5];
        end
        @(posedge clk);
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {clk, cyc, stb, we, retry, txd, rxd, busy, await_ack, pdet} = '0;
        {adr, energy, qual, wdat, cycles, err_count, num_checks} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        pin_chk(6'h00);
        rd(`ADIV_OFS_CTRL, 32'h0);
        rd(`ADIV_OFS_STATUS, 32'h0);
        wr(`ADIV_OFS_CTRL, 32'h4);
        pin_chk(pv(1, 0, 0));
        rd(8'h10, 32'h0);
        wr(`ADIV_OFS_STATUS, 32'h7);
        rd(`ADIV_OFS_STATUS, 32'h0);
        wr(`ADIV_OFS_SWAP, 32'h1);
        pin_chk(pv(1, 0, 1));
        rd(`ADIV_OFS_STATUS, 32'h4);
        wr(`ADIV_OFS_CTRL, 32'hc);
        pin_chk(pv(1, 1, 1));
        wr(`ADIV_OFS_SWAP, 32'h1);
        pin_chk(pv(1, 1, 0));
        wr(`ADIV_OFS_CTRL, 32'h5);
        pulse(0);
        repeat (3) @(negedge clk);
        pin_chk(pv(1, 0, 1));
        pulse(0);
        pulse(0);
        repeat (3) @(negedge clk);
        pin_chk(pv(1, 0, 1));
        pulse(1);
        pulse(2);
        rd(`ADIV_OFS_STATUS, 32'h7);
        wr(`ADIV_OFS_CTRL, 32'h4);
        pulse(0);
        repeat (3) @(negedge clk);
        pin_chk(pv(1, 0, 1));
        wr(`ADIV_OFS_THRESH, 32'h8040);
        rd(`ADIV_OFS_THRESH, 32'h8040);
        busy <= 1'b1;
        wr(`ADIV_OFS_CTRL, 32'h6);
        count(40);
        `CHK(t, 0)
        busy <= 1'b0;
        await_ack <= 1'b1;
        count(40);
        `CHK(t, 0)
        await_ack <= 1'b0;
        energy <= 8'h40;
        count(40);
        `CHK(t, 0)
        energy <= 8'h3f;
        count(32);
        `CHK(t, 2)
        qual <= 8'h81;
        pulse(3);
        count(10);
        `CHK(t, 0)
        repeat (8) @(posedge clk);
        qual <= 8'h80;
        pulse(3);
        count(32);
        `CHK(t, 2)
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        pin_chk(6'h00);
        rd(`ADIV_OFS_STATUS, 32'h0);
        rd(`ADIV_OFS_CTRL, 32'h0);
        finish_test();
    end
endmodule // testbench
